//--- bbx_execute.sv
// Execute stage for add, AND, bit clear, bit set and bit test skip.
// Functional notes
// - Literal add into accumulator; updates carry, digit carry, zero.
// - Register add with accumulator; updates carry, digit carry, zero.
// - Destination bit 0 to accumulator, 1 to register.
// - Literal AND into accumulator; only zero flag changes.
// - Register AND to destination; only zero flag changes.
// - Bit clear zeroes selected bit; flags untouched.
// - Bit set ones selected bit; flags untouched.
// - Skip on clear bit: next becomes one-cycle nop.
// - Skip on set bit: next becomes one-cycle nop.
// - Port read-modify-write uses sensed pin levels.
//
// Our own choices: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
`include "bbx_params.svh"
module bbx_execute (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic opValid,
  input wire logic [3:0] opCode,
  input wire logic [7:0] literal,
  input wire logic [6:0] regAddr,
  input wire logic destSel,
  input wire logic [2:0] bitIndex,
  input wire logic [7:0] regReadData,
  input wire logic regIsPort,
  input wire logic [7:0] portPins,
  output logic opReady,
  output logic [7:0] accValue,
  output logic carryFlag,
  output logic digit_carry_flag,
  output logic zeroFlag,
  output logic regWriteEn,
  output logic [6:0] regWriteAddr,
  output logic [7:0] regWriteData,
  output logic skipNop
);
  // Working accumulator.
  logic [7:0] acc;
  logic [7:0] next_acc;
  // Status flags held here for the core.
  logic cFlag;
  logic dcFlag;
  logic zFlag;
  logic next_cFlag;
  logic next_dcFlag;
  logic next_zFlag;
  // File register write port, registered.
  logic wrEn;
  logic [6:0] wrAddr;
  logic [7:0] wrData;
  logic next_wrEn;
  logic [6:0] next_wrAddr;
  logic [7:0] next_wrData;
  // Sequencer state.
  bbx_pkg::bbx_state_t state;
  bbx_pkg::bbx_state_t next_state;
  // Pin levels after synchronisation.
  logic [7:0] pinLevel;
  // Operand actually used from the file register side.
  logic [7:0] regOperand;
  // Second adder operand, literal or register.
  logic [7:0] addB;
  // Adder results.
  logic [7:0] sum;
  logic carryOut;
  logic digitCarryOut;
  // Decoded operation.
  bbx_pkg::bbx_op_t op;
  // Instruction taken this cycle.
  logic takeOp;
  // Selected bit of the operand.
  logic testBit;

  // One-hot mask for a bit index, used by clear, set and test.
  function automatic logic [7:0] bitMask(input logic [2:0] idx);
    bitMask = 8'h01 << idx;
  endfunction

  // Zero detection shared by every zero flag update.
  function automatic logic isZero(input logic [7:0] v);
    isZero = (v == 8'h00);
  endfunction

  // Sensed pin levels for port registers.
  bbx_pin_sync uPinSync (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .pinIn(portPins),
    .pinLevel(pinLevel)
  );

  // Shared adder for both add forms.
  bbx_adder uAdder (
    .addA(acc),
    .addB(addB),
    .sum(sum),
    .carryOut(carryOut),
    .digitCarryOut(digitCarryOut)
  );

  // Operand selection and instruction acceptance.
  always_comb
  begin
    op = bbx_pkg::bbx_op_t'(opCode);
    // Port registers are read back from the pins, not the latch.
    regOperand = regIsPort ? pinLevel : regReadData;
    addB = (op == bbx_pkg::BBX_OP_ADD_LITERAL_TO_ACC) ? literal : regOperand;
    testBit = |(regOperand & bitMask(bitIndex));
    // During the substituted nop the fetched instruction is refused.
    opReady = (state == bbx_pkg::BBX_ST_RUN);
    takeOp = opValid && opReady;
  end

  // Next-state logic for accumulator, flags, write port and sequencer.
  always_comb
  begin
    next_acc = acc;
    next_cFlag = cFlag;
    next_dcFlag = dcFlag;
    next_zFlag = zFlag;
    next_wrEn = 1'b0;
    next_wrAddr = wrAddr;
    next_wrData = wrData;
    next_state = state;
    case (state)
      bbx_pkg::BBX_ST_RUN:
      begin
        if (takeOp)
        begin
          case (op)
            bbx_pkg::BBX_OP_ADD_LITERAL_TO_ACC:
            begin
              next_acc = sum;
              next_cFlag = carryOut;
              next_dcFlag = digitCarryOut;
              next_zFlag = isZero(sum);
            end
            bbx_pkg::BBX_OP_ADD_ACC_AND_REG:
            begin
              next_cFlag = carryOut;
              next_dcFlag = digitCarryOut;
              next_zFlag = isZero(sum);
              if (destSel == `BBX_DEST_ACC)
              begin
                next_acc = sum;
              end
              else
              begin
                next_wrEn = 1'b1;
                next_wrAddr = regAddr;
                next_wrData = sum;
              end
            end
            bbx_pkg::BBX_OP_AND_LITERAL_WITH_ACC:
            begin
              next_acc = acc & literal;
              next_zFlag = isZero(acc & literal);
            end
            bbx_pkg::BBX_OP_AND_ACC_WITH_REG:
            begin
              next_zFlag = isZero(acc & regOperand);
              if (destSel == `BBX_DEST_ACC)
              begin
                next_acc = acc & regOperand;
              end
              else
              begin
                next_wrEn = 1'b1;
                next_wrAddr = regAddr;
                next_wrData = acc & regOperand;
              end
            end
            bbx_pkg::BBX_OP_REG_BIT_CLEAR:
            begin
              next_wrEn = 1'b1;
              next_wrAddr = regAddr;
              next_wrData = regOperand & ~bitMask(bitIndex);
            end
            bbx_pkg::BBX_OP_REG_BIT_SET:
            begin
              next_wrEn = 1'b1;
              next_wrAddr = regAddr;
              next_wrData = regOperand | bitMask(bitIndex);
            end
            bbx_pkg::BBX_OP_SKIP_IF_BIT_CLEAR:
            begin
              if (!testBit)
              begin
                next_state = bbx_pkg::BBX_ST_NOP;
              end
            end
            bbx_pkg::BBX_OP_SKIP_IF_BIT_SET:
            begin
              if (testBit)
              begin
                next_state = bbx_pkg::BBX_ST_NOP;
              end
            end
            default:
            begin
              next_acc = acc;
            end
          endcase
        end
      end
      bbx_pkg::BBX_ST_NOP:
      begin
        // The discarded instruction leaves accumulator, flags and registers untouched; the sequencer returns to run.
        next_state = bbx_pkg::BBX_ST_RUN;
      end
      default:
      begin
        next_state = bbx_pkg::BBX_ST_RUN;
      end
    endcase
  end

  // Registers only.
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      acc <= `BBX_ACC_RESET;
      cFlag <= 1'b0;
      dcFlag <= 1'b0;
      zFlag <= 1'b0;
      wrEn <= 1'b0;
      wrAddr <= 7'h00;
      wrData <= 8'h00;
      state <= bbx_pkg::BBX_ST_RUN;
    end
    else
    begin
      acc <= next_acc;
      cFlag <= next_cFlag;
      dcFlag <= next_dcFlag;
      zFlag <= next_zFlag;
      wrEn <= next_wrEn;
      wrAddr <= next_wrAddr;
      wrData <= next_wrData;
      state <= next_state;
    end
  end

  // Outputs straight from registers.
  always_comb
  begin
    accValue = acc;
    carryFlag = cFlag;
    digit_carry_flag = dcFlag;
    zeroFlag = zFlag;
    regWriteEn = wrEn;
    regWriteAddr = wrAddr;
    regWriteData = wrData;
    skipNop = (state == bbx_pkg::BBX_ST_NOP);
  end
endmodule

//--- bbx_params.svh
// Constants for the byte and bit operation execute stage.
`ifndef BBX_PARAMS_SVH
`define BBX_PARAMS_SVH
`define BBX_DATA_W 8
`define BBX_ADDR_W 7
`define BBX_BIT_W 3
`define BBX_ACC_RESET 8'h00
`define BBX_FLAG_C 0
`define BBX_FLAG_DC 1
`define BBX_FLAG_Z 2
`define BBX_NIBBLE_TOP 3
`define BBX_DEST_ACC 1'h0
`define BBX_DEST_REG 1'h1
`define BBX_SKIP_CYCLES 2
`endif

//--- bbx_pkg.sv
// Types shared by the execute stage files.
package bbx_pkg;
  // Operation codes handed over by the instruction decoder.
  typedef enum logic [3:0] {
    BBX_OP_NONE = 4'h0,
    BBX_OP_ADD_LITERAL_TO_ACC = 4'h1,
    BBX_OP_ADD_ACC_AND_REG = 4'h2,
    BBX_OP_AND_LITERAL_WITH_ACC = 4'h3,
    BBX_OP_AND_ACC_WITH_REG = 4'h4,
    BBX_OP_REG_BIT_CLEAR = 4'h5,
    BBX_OP_REG_BIT_SET = 4'h6,
    BBX_OP_SKIP_IF_BIT_CLEAR = 4'h7,
    BBX_OP_SKIP_IF_BIT_SET = 4'h8
  } bbx_op_t;
  // Execute sequencer states, one-hot.
  typedef enum logic [1:0] {
    BBX_ST_RUN = 2'h1,
    BBX_ST_NOP = 2'h2
  } bbx_state_t;
endpackage

//--- bbx_adder.sv
// Eight-bit adder with carry out of bit 7 and of bit 3.
`timescale 1ns/1ps
`include "bbx_params.svh"
module bbx_adder (
  input wire logic [7:0] addA,
  input wire logic [7:0] addB,
  output logic [7:0] sum,
  output logic carryOut,
  output logic digitCarryOut
);
  // Low nibble sum, one bit wider to catch the carry out of bit 3.
  logic [4:0] lowSum;
  // Full sum, one bit wider to catch the carry out of bit 7.
  logic [8:0] fullSum;

  // The two carries come from two separate sums of the same operands: a low-nibble sum and a full sum.
  always_comb
  begin
    lowSum = {1'b0, addA[3:0]} + {1'b0, addB[3:0]};
    fullSum = {1'b0, addA} + {1'b0, addB};
    sum = fullSum[7:0];
    carryOut = fullSum[8];
    digitCarryOut = lowSum[4];
  end
endmodule

//--- bbx_pin_sync.sv
// Three-stage synchroniser for the sensed port pin levels.
`timescale 1ns/1ps
`include "bbx_params.svh"
module bbx_pin_sync (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic [7:0] pinIn,
  output logic [7:0] pinLevel
);
  // First stage, read only by the second.
  logic [7:0] syncA;
  // Second stage.
  logic [7:0] syncB;
  // Third stage.
  logic [7:0] syncC;
  // Next value of the accepted level.
  logic [7:0] next_pinLevel;

  // A bit is taken only when the second and third stages agree, which
  // filters a one-cycle glitch at the cost of one more cycle of delay.
  always_comb
  begin
    for (int i = 0; i < 8; i++)
    begin
      next_pinLevel[i] = (syncB[i] == syncC[i]) ? syncC[i] : pinLevel[i];
    end
  end

  // Registers only.
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      syncA <= 8'h00;
      syncB <= 8'h00;
      syncC <= 8'h00;
      pinLevel <= 8'h00;
    end
    else
    begin
      syncA <= pinIn;
      syncB <= syncA;
      syncC <= syncB;
      pinLevel <= next_pinLevel;
    end
  end
endmodule

//--- bbx_execute_monitor.sv
// Port assertions for the byte and bit operation execute stage.
`timescale 1ns/1ps
module bbx_execute_monitor (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic opValid,
  input wire logic [3:0] opCode,
  input wire logic [7:0] literal,
  input wire logic [6:0] regAddr,
  input wire logic destSel,
  input wire logic [2:0] bitIndex,
  input wire logic [7:0] regReadData,
  input wire logic regIsPort,
  input wire logic opReady,
  input wire logic [7:0] accValue,
  input wire logic carryFlag,
  input wire logic digit_carry_flag,
  input wire logic zeroFlag,
  input wire logic regWriteEn,
  input wire logic [6:0] regWriteAddr,
  input wire logic [7:0] regWriteData,
  input wire logic skipNop
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  // A taken op on plain memory; port operands pass a synchroniser, so the bench judges them.
  wire t = opValid && opReady && !regIsPort;
  // The bit that a test instruction looks at.
  wire tb = regReadData[bitIndex];
  chk_add_literal: assert property (t && opCode == 4'h1 |=>
    {carryFlag, accValue} == $past(accValue) + $past(literal) && zeroFlag == (accValue == 8'h00))
    else $error("literal add result wrong");
  chk_reg_add_acc: assert property (t && opCode == 4'h2 && !destSel |=>
    {carryFlag, accValue} == $past(accValue) + $past(regReadData))
    else $error("register add result wrong");
  chk_reg_dest: assert property (t && (opCode == 4'h2 || opCode == 4'h4) && destSel |=>
    regWriteEn && regWriteAddr == $past(regAddr) && accValue == $past(accValue))
    else $error("register destination ignored");
  chk_and_literal: assert property (t && opCode == 4'h3 |=>
    accValue == ($past(accValue) & $past(literal)) && $stable(carryFlag) && $stable(digit_carry_flag))
    else $error("literal and result wrong");
  chk_and_reg: assert property (t && opCode == 4'h4 && !destSel |=>
    accValue == ($past(accValue) & $past(regReadData)) && $stable(carryFlag))
    else $error("register and result wrong");
  chk_bit_clear: assert property (t && opCode == 4'h5 |=> regWriteEn && $stable(zeroFlag) &&
    regWriteData == ($past(regReadData) & ~(8'h01 << $past(bitIndex))))
    else $error("bit clear wrong");
  chk_bit_set: assert property (t && opCode == 4'h6 |=> regWriteEn && $stable(carryFlag) &&
    regWriteData == ($past(regReadData) | (8'h01 << $past(bitIndex))))
    else $error("bit set wrong");
  chk_skip_taken: assert property (t && (opCode == 4'h7 && !tb || opCode == 4'h8 && tb) |=>
    skipNop && !opReady ##1 !skipNop)
    else $error("skip not taken");
  chk_skip_none: assert property (t && (opCode == 4'h7 && tb || opCode == 4'h8 && !tb) |=>
    !skipNop)
    else $error("skip taken wrongly");
  chk_nop_discard: assert property (skipNop |=> $stable(accValue) && !regWriteEn)
    else $error("refused op had an effect");
endmodule
bind bbx_execute bbx_execute_monitor i_bbx_execute_monitor (.ref_clk, .sys_rst, .opValid,
  .opCode, .literal, .regAddr, .destSel, .bitIndex, .regReadData, .regIsPort, .opReady,
  .accValue, .carryFlag, .digit_carry_flag, .zeroFlag, .regWriteEn, .regWriteAddr,
  .regWriteData, .skipNop);

//--- bbx_file_model.sv
// File register memory model that answers the execute stage.
`timescale 1ns/1ps
module bbx_file_model (
  input wire logic ref_clk,
  input wire logic [6:0] regAddr,
  input wire logic regIsPort,
  input wire logic [7:0] portPins,
  input wire logic regWriteEn,
  input wire logic [6:0] regWriteAddr,
  input wire logic [7:0] regWriteData,
  output logic [7:0] regReadData
);
  logic [7:0] mem [128];
  // A port shows its latch, the inverse of the pins, so reading the latch is caught.
  assign regReadData = regIsPort ? ~portPins : mem[regAddr];
  initial for (int i = 0; i < 128; i++) mem[i] = 8'(i * 37);
  // Writes land at the edge that ends the strobe cycle.
  always @(posedge ref_clk) if (regWriteEn) mem[regWriteAddr] <= regWriteData;
endmodule

//--- byte_bit_op_execute_bench.sv
// Self-checking bench for the execute stage.
`timescale 1ns/1ps
module byte_bit_op_execute_bench;
  logic ref_clk = 0, sys_rst = 1, opValid = 0, destSel = 0, regIsPort = 0;
  logic [3:0] opCode = 0;
  logic [7:0] literal = 0, portPins = 0, eAcc = 0, eWd = 0;
  logic [6:0] regAddr = 0, eWa = 0;
  logic [2:0] bitIndex = 0, eFl = 0;
  logic eSkip = 0, eWe = 0;
  wire opReady, carryFlag, digit_carry_flag, zeroFlag, regWriteEn, skipNop;
  wire [7:0] accValue, regWriteData, regReadData;
  wire [6:0] regWriteAddr;
  int fails = 0, checks = 0, cyc = 0;
  bbx_execute i_bbx_execute (.ref_clk, .sys_rst, .opValid, .opCode, .literal, .regAddr,
    .destSel, .bitIndex, .regReadData, .regIsPort, .portPins, .opReady, .accValue,
    .carryFlag, .digit_carry_flag, .zeroFlag, .regWriteEn, .regWriteAddr, .regWriteData,
    .skipNop);
  bbx_file_model i_bbx_file_model (.ref_clk, .regAddr, .regIsPort, .portPins, .regWriteEn,
    .regWriteAddr, .regWriteData, .regReadData);
  always #2 ref_clk = ~ref_clk;
  // Sum with carry out of bit 7 and bit 3, as {carry, digit carry, sum}.
  function automatic logic [9:0] add8(input logic [7:0] a, input logic [7:0] b);
    logic [8:0] s;
    s = a + b;
    return {s[8], ({1'b0, a[3:0]} + b[3:0]) > 5'h0F, s[7:0]};
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp)
    begin
      fails++;
      $display("unexpected at %0t got %0h exp %0h", $time, got, exp);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // Presents one op, checks the previous one, then predicts this one.
  task automatic step(input logic [3:0] op, input logic [7:0] lit);
    logic [7:0] d, a, res;
    logic [9:0] r;
    logic rf;
    @(posedge ref_clk);
    opValid <= (op != 4'h0);
    opCode <= op;
    literal <= lit;
    regAddr <= 7'($urandom);
    destSel <= 1'($urandom);
    bitIndex <= 3'($urandom);
    #1;
    chk(accValue, eAcc);
    chk({carryFlag, digit_carry_flag, zeroFlag}, eFl);
    chk({opReady, skipNop, regWriteEn}, {!eSkip, eSkip, eWe});
    if (eWe) chk(regWriteData, eWd);
    if (eWe) chk(regWriteAddr, eWa);
    // Ports count by their pins; a refused op leaves everything alone.
    d = regIsPort ? portPins : regReadData;
    r = add8(eAcc, opCode == 4'h1 ? literal : d);
    a = eAcc & (opCode == 4'h3 ? literal : d);
    res = (opCode < 4'h3) ? r[7:0] : (opCode < 4'h5) ? a : (opCode == 4'h5) ?
      d & ~(8'h01 << bitIndex) : d | (8'h01 << bitIndex);
    rf = eSkip;
    eSkip = 0;
    eWe = 0;
    if (opValid && !rf)
    begin
      eSkip = (opCode == 4'h7 && !d[bitIndex]) || (opCode == 4'h8 && d[bitIndex]);
      if (opCode == 4'h1 || opCode == 4'h2) eFl = {r[9:8], r[7:0] == 8'h00};
      if (opCode == 4'h3 || opCode == 4'h4) eFl[0] = (a == 8'h00);
      if (opCode inside {4'h1, 4'h3} || (opCode inside {4'h2, 4'h4} && !destSel)) eAcc = res;
      else if (opCode inside {[4'h2:4'h6]})
      begin
        eWe = 1;
        eWd = res;
        eWa = regAddr;
      end
    end
  endtask
  // Cuts a hang short; the whole run needs about 500 cycles.
  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 2000)
    begin
      fails++;
      finish_test();
    end
  end
  initial
  begin
    void'($urandom(32'h3146));
    repeat (8) @(posedge ref_clk);
    sys_rst <= 1'b0;
    step(4'h1, 8'hFB);
    step(4'h1, 8'h05);
    for (int k = 1; k < 10; k++) step(4'(k), 8'hFF);
    step(4'h0, 8'h00);
    $display("test corner done");
    repeat (400) step(4'($urandom_range(0, 9)), 8'($urandom));
    // An idle op first, so the last random op is judged before the port select moves.
    step(4'h0, 8'h00);
    $display("test random done");
    @(posedge ref_clk);
    portPins <= 8'h5A;
    regIsPort <= 1'b1;
    repeat (6) step(4'h0, 8'h00);
    repeat (60) step(4'($urandom_range(1, 8)), 8'($urandom));
    step(4'h0, 8'h00);
    $display("test port done");
    finish_test();
  end
endmodule
